// ### rtl/rio_pkg.sv
// Package for the memory and port instruction execution block.
// Assumes a single processor clock domain and one-byte opcodes.
package rio_pkg;
    localparam int unsigned DW = 4;
    // Opcode values of the group.
    localparam logic [7:0] OP_WR_MEM   = 8'he0;
    localparam logic [7:0] OP_WR_RPORT = 8'he1;
    localparam logic [7:0] OP_WR_OPORT = 8'he2;
    localparam logic [7:0] OP_PGM_ACC  = 8'he3;
    localparam logic [7:0] OP_SUB_MEM  = 8'he8;
    localparam logic [7:0] OP_RD_MEM   = 8'he9;
    localparam logic [7:0] OP_RD_OPORT = 8'hea;
    localparam logic [7:0] OP_ADD_MEM  = 8'heb;
    localparam logic [5:0] OP_WR_ST_HI = 6'h39;
    localparam logic [5:0] OP_RD_ST_HI = 6'h3b;
    localparam logic [5:0] OP_SEL_HI   = 6'h08;
    localparam logic [7:0] OP_BANK     = 8'hfd;
    localparam logic [3:0] ACC_RST     = 4'h0;
    localparam logic       CY_RST      = 1'b0;
    // Memory address as latched by the select instruction.
    typedef struct packed {
        logic [2:0] bank;
        logic [1:0] chip;
        logic [1:0] reg_n;
        logic [3:0] chr;
    } rio_addr_t;
    // Accumulator with carry.
    typedef struct packed {
        logic       cy;
        logic [3:0] acc;
    } rio_alu_t;
endpackage

// ### rtl/rio_mem.sv
// Data memory of one bank set: data and status characters plus chip output ports.
// Assumes one write per cycle, addressed by the latched select address.
`timescale 1ns/1ps
`default_nettype none
module rio_mem #(
    parameter int unsigned BANKS = 8,
    parameter int unsigned CHIPS = 4,
    parameter int unsigned REGS  = 4,
    parameter int unsigned CHARS = 16,
    parameter int unsigned STATS = 4
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire rio_pkg::rio_addr_t addr_in,
    input  wire logic          wr_data_in,
    input  wire logic          wr_stat_in,
    input  wire logic          wr_port_in,
    input  wire logic [1:0]    stat_sel_in,
    input  wire logic [3:0]    wdata_in,
    output logic [3:0]         data_out,
    output logic [3:0]         stat_out,
    output logic [BANKS*CHIPS*4-1:0] ports_out
);
    localparam int unsigned NREG = BANKS * CHIPS * REGS;
    logic [3:0] data_q [NREG*CHARS];
    logic [3:0] stat_q [NREG*STATS];
    logic [3:0] port_q [BANKS*CHIPS];
    logic [$clog2(NREG)-1:0] ri;
    logic [$clog2(BANKS*CHIPS)-1:0] ci;

    // Register and chip index from the select address.
    assign ri = {addr_in.bank, addr_in.chip, addr_in.reg_n};
    assign ci = {addr_in.bank, addr_in.chip};
    assign data_out = data_q[{ri, addr_in.chr}];
    assign stat_out = stat_q[{ri, stat_sel_in}];

    // Character writes; no reset, memory contents are undefined at power-up by design.
    always_ff @(posedge clk_in) begin
        if (wr_data_in) begin
            data_q[{ri, addr_in.chr}] <= wdata_in;
        end
        if (wr_stat_in) begin
            stat_q[{ri, stat_sel_in}] <= wdata_in;
        end
    end

    // Output port latches hold until the same chip is written again.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < BANKS*CHIPS; i++) begin
                port_q[i] <= 4'h0;
            end
        end else if (wr_port_in) begin
            port_q[ci] <= wdata_in;
        end
    end

    always_comb begin
        for (int i = 0; i < BANKS*CHIPS; i++) begin
            ports_out[i*4 +: 4] = port_q[i];
        end
    end
endmodule
`default_nettype wire

// ### rtl/rio_exec.sv
// Execution unit for the memory and port instruction group of a 4-bit core.
// Assumes one instruction byte per cycle on OPC_IN with OPC_VLD_IN high.
// Functional notes
// - Status write stores accumulator, keeps acc, carry.
// - Memory read loads data character into accumulator.
// - Port read copies input lines into accumulator; output lines give the mask value.
// - Status read loads status character n.
// - Add memory plus carry; carry from overflow.
// - Subtract adds complemented character and complemented carry.
// - Carry set means no borrow occurred.
// - Incoming carry one means pending borrow.
// - Every group instruction is one byte.
// - Addresses come from bank and select.
// - Port write sends accumulator to memory chip.
// - Other port write drives selected port chip.
// - Program memory access moves one half.
// - Status write opcodes use low two bits.
// - Select sends register pair as address.
// - Half toggle alternates, cleared on reset.
`timescale 1ns/1ps
`default_nettype none
module rio_exec #(
    parameter int unsigned OPORTS = 16
) (
    input  wire logic                CLK_IN,
    input  wire logic                RST_IN,
    input  wire logic                OPC_VLD_IN,
    input  wire logic [7:0]          OPC_IN,
    input  wire logic [7:0]          PAIR_IN,
    input  wire logic [2:0]          BANK_IN,
    input  wire logic [3:0]          OPORT_IN_IN,
    input  wire logic [3:0]          OPORT_DIR_IN,
    input  wire logic [3:0]          OPORT_MASK_IN,
    output logic [3:0]               ACC_OUT,
    output logic                     CY_OUT,
    output logic [OPORTS*4-1:0]      OPORT_OUT,
    output logic [127:0]             RPORT_OUT,
    output logic                     PGM_STB_OUT,
    output logic                     PGM_HALF_OUT,
    output logic [3:0]               PGM_DATA_OUT
);
    rio_pkg::rio_alu_t  alu_q, alu_d;
    rio_pkg::rio_addr_t addr_q;
    logic [2:0] bank_q;
    logic [3:0] port_q [OPORTS];
    logic       half_q;
    logic       pstb_q;
    logic [3:0] pdat_q;
    logic [3:0] mem_data, mem_stat;
    logic       is_wst, is_rst, op_wrm, op_wmp;

    // Add with carry in, truncated to four bits plus carry out.
    function automatic rio_pkg::rio_alu_t add4(input logic [3:0] a, input logic [3:0] b,
                                               input logic ci);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
        return {s[4], s[3:0]};
    endfunction

    assign is_wst = OPC_VLD_IN && (OPC_IN[7:2] == rio_pkg::OP_WR_ST_HI);
    assign is_rst = OPC_VLD_IN && (OPC_IN[7:2] == rio_pkg::OP_RD_ST_HI);
    // Program memory access also writes the data character at the same address.
    assign op_wrm = OPC_VLD_IN && (OPC_IN == rio_pkg::OP_WR_MEM || OPC_IN == rio_pkg::OP_PGM_ACC);
    assign op_wmp = OPC_VLD_IN && (OPC_IN == rio_pkg::OP_WR_RPORT);

    rio_mem u_mem (
        .clk_in      (CLK_IN),
        .rst_in      (RST_IN),
        .addr_in     (addr_q),
        .wr_data_in  (op_wrm),
        .wr_stat_in  (is_wst),
        .wr_port_in  (op_wmp),
        .stat_sel_in (OPC_IN[1:0]),
        .wdata_in    (alu_q.acc),
        .data_out    (mem_data),
        .stat_out    (mem_stat),
        .ports_out   (RPORT_OUT)
    );

    // Bank latch read only by the select; select address latch used by later memory, status and port write instructions.
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            bank_q <= 3'h0;
            addr_q <= '0;
        end else if (OPC_VLD_IN) begin
            if (OPC_IN == rio_pkg::OP_BANK) begin
                bank_q <= BANK_IN;
            end
            if (OPC_IN[7:4] == rio_pkg::OP_SEL_HI[5:2] && OPC_IN[0]) begin
                addr_q <= {bank_q, PAIR_IN};
            end
        end
    end

    // Accumulator and carry next value; each opcode is decoded from one byte.
    always_comb begin
        alu_d = alu_q;
        if (is_rst) begin
            alu_d.acc = mem_stat;
        end else if (OPC_VLD_IN) begin
            unique case (OPC_IN)
                rio_pkg::OP_RD_MEM:   alu_d.acc = mem_data;
                // Output lines return the mask value, not their driven level.
                rio_pkg::OP_RD_OPORT: alu_d.acc = (OPORT_IN_IN & ~OPORT_DIR_IN)
                                                | (OPORT_MASK_IN & OPORT_DIR_IN);
                rio_pkg::OP_ADD_MEM:  alu_d = add4(alu_q.acc, mem_data, alu_q.cy);
                // Carry high on entry is a pending borrow; carry out high means no borrow.
                rio_pkg::OP_SUB_MEM:  alu_d = add4(alu_q.acc, ~mem_data, ~alu_q.cy);
                default:              alu_d = alu_q;
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            alu_q <= {rio_pkg::CY_RST, rio_pkg::ACC_RST};
        end else begin
            alu_q <= alu_d;
        end
    end

    // Port chip output latches, indexed by the character field of the select address.
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            for (int i = 0; i < OPORTS; i++) begin
                port_q[i] <= 4'h0;
            end
        end else if (OPC_VLD_IN && OPC_IN == rio_pkg::OP_WR_OPORT) begin
            port_q[addr_q.chr] <= alu_q.acc;
        end
    end

    always_comb begin
        for (int i = 0; i < OPORTS; i++) begin
            OPORT_OUT[i*4 +: 4] = port_q[i];
        end
    end

    // Program memory half access; the toggle picks which half this pass moves.
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            half_q <= 1'b0;
            pstb_q <= 1'b0;
            pdat_q <= 4'h0;
        end else begin
            pstb_q <= OPC_VLD_IN && OPC_IN == rio_pkg::OP_PGM_ACC;
            if (OPC_VLD_IN && OPC_IN == rio_pkg::OP_PGM_ACC) begin
                half_q <= ~half_q;
                pdat_q <= alu_q.acc;
            end
        end
    end

    assign ACC_OUT      = alu_q.acc;
    assign CY_OUT       = alu_q.cy;
    assign PGM_STB_OUT  = pstb_q;
    assign PGM_DATA_OUT = pdat_q;
    assign PGM_HALF_OUT = ~half_q; // Half that the last strobe carried.

    a_add_carry: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        OPC_VLD_IN && OPC_IN == rio_pkg::OP_ADD_MEM |=>
        {CY_OUT, ACC_OUT} == 5'($past(ACC_OUT)) + 5'($past(mem_data)) + 5'($past(CY_OUT)))
        else $error("add result wrong");
    a_sub_borrow: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        OPC_VLD_IN && OPC_IN == rio_pkg::OP_SUB_MEM |=>
        {CY_OUT, ACC_OUT} == {1'b0, $past(ACC_OUT)} + {1'b0, ~$past(mem_data)}
                             + {4'h0, !$past(CY_OUT)})
        else $error("subtract result wrong");
    a_sub_nobrw: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        OPC_VLD_IN && OPC_IN == rio_pkg::OP_SUB_MEM && ACC_OUT > mem_data && !CY_OUT |=> CY_OUT)
        else $error("no borrow must set carry");
    a_rd_mem: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        OPC_VLD_IN && OPC_IN == rio_pkg::OP_RD_MEM |=> ACC_OUT == $past(mem_data) && $stable(CY_OUT))
        else $error("memory read wrong");
    a_rd_stat: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        is_rst |=> ACC_OUT == $past(mem_stat) && $stable(CY_OUT))
        else $error("status read wrong");
    a_wr_stat: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        is_wst |=> $stable(ACC_OUT) && $stable(CY_OUT) && mem_stat == $past(ACC_OUT)
                   || OPC_IN[1:0] != $past(OPC_IN[1:0]))
        else $error("status write wrong");
    a_rd_port: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        OPC_VLD_IN && OPC_IN == rio_pkg::OP_RD_OPORT && OPORT_DIR_IN == 4'h0
        |=> ACC_OUT == $past(OPORT_IN_IN))
        else $error("port read wrong");
    a_half_flip: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        OPC_VLD_IN && OPC_IN == rio_pkg::OP_PGM_ACC |=> PGM_STB_OUT && half_q != $past(half_q))
        else $error("half toggle wrong");
    a_wr_oport: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        OPC_VLD_IN && OPC_IN == rio_pkg::OP_WR_OPORT |=> port_q[$past(addr_q.chr)] == $past(ACC_OUT))
        else $error("port write wrong");
    c_add: cover property (@(posedge CLK_IN) OPC_VLD_IN && OPC_IN == rio_pkg::OP_ADD_MEM ##1 CY_OUT);
    c_sub: cover property (@(posedge CLK_IN) OPC_VLD_IN && OPC_IN == rio_pkg::OP_SUB_MEM ##1 !CY_OUT);
    c_pgm: cover property (@(posedge CLK_IN) PGM_STB_OUT ##1 !PGM_STB_OUT [*1] ##1 PGM_STB_OUT);
endmodule
`default_nettype wire

// ### bench/rio_rom_model.sv
// Model of the selected ROM chip's four-line port as the executor sees it.
// Assumes the bench presents the selected chip index and the pin levels.
`timescale 1ns/1ps
`default_nettype none
module rio_rom_model (
    input  wire logic [3:0]  chip_in,
    input  wire logic [3:0]  pins_in,
    input  wire logic [63:0] latch_in,
    output logic      [3:0]  line_out,
    output logic      [3:0]  dir_out,
    output logic      [3:0]  mask_out
);
    // Direction and fixed read value are chosen per chip when it is made; values arbitrary.
    // Output lines carry the chip's own latch, so a reader that ignores the mask goes wrong.
    always_comb begin
        dir_out  = {chip_in[0], chip_in[3], chip_in[1], chip_in[2]};
        mask_out = ~chip_in;
        line_out = (pins_in & ~dir_out) | (latch_in[chip_in*4 +: 4] & dir_out);
    end
endmodule
`default_nettype wire

// ### bench/rio_exec_bench.sv
// Self-checking bench for the memory and port instruction executor.
// Assumes the design package and the ROM port model beside this file.
`timescale 1ns/1ps
`default_nettype none
module rio_exec_bench;
    typedef struct packed {
        logic [3:0]   acc;
        logic         cy;
        logic [63:0]  op;
        logic [127:0] rp;
        logic         stb;
        logic         half;
    } rio_exp_t;
    logic         CLK_IN, RST_IN, OPC_VLD_IN, CY_OUT, PGM_STB_OUT, PGM_HALF_OUT, pend, h;
    logic [7:0]   OPC_IN, PAIR_IN, pair_q;
    logic [2:0]   BANK_IN, bank_q;
    logic [3:0]   OPORT_IN_IN, OPORT_DIR_IN, OPORT_MASK_IN, ACC_OUT, PGM_DATA_OUT, pins;
    logic [63:0]  OPORT_OUT;
    logic [127:0] RPORT_OUT;
    logic [3:0]   dat [int];
    logic [3:0]   sts [int];
    logic [7:0]   seq [20];
    rio_exp_t     m, e, q [$];
    int           miscompares, tests_run;
    // Free-running processor clock.
    initial begin
        CLK_IN = 1'b0;
        forever #5 CLK_IN = ~CLK_IN;
    end
    rio_exec i_dut (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .OPC_VLD_IN(OPC_VLD_IN),
        .OPC_IN(OPC_IN), .PAIR_IN(PAIR_IN), .BANK_IN(BANK_IN), .OPORT_IN_IN(OPORT_IN_IN),
        .OPORT_DIR_IN(OPORT_DIR_IN), .OPORT_MASK_IN(OPORT_MASK_IN), .ACC_OUT(ACC_OUT),
        .CY_OUT(CY_OUT), .OPORT_OUT(OPORT_OUT), .RPORT_OUT(RPORT_OUT),
        .PGM_STB_OUT(PGM_STB_OUT), .PGM_HALF_OUT(PGM_HALF_OUT), .PGM_DATA_OUT(PGM_DATA_OUT));
    rio_rom_model i_rom (.chip_in(pair_q[3:0]), .pins_in(pins), .latch_in(OPORT_OUT),
        .line_out(OPORT_IN_IN), .dir_out(OPORT_DIR_IN), .mask_out(OPORT_MASK_IN));
    // Wide compare shared by both kinds of result.
    task automatic chk_port(input logic [195:0] got, input logic [195:0] exp);
        tests_run++;
        if (got !== exp || $isunknown(exp)) begin
            miscompares++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_alu(input logic [4:0] got, input logic [4:0] exp);
        chk_port({191'h0, got}, {191'h0, exp});
    endtask
    // Drives one instruction and advances the reference model; v feeds PAIR_IN, BANK_IN and the pin levels.
    task automatic exec(input logic [7:0] op, input logic [7:0] v);
        int a;
        int s;
        @(posedge CLK_IN);
        OPC_IN     <= op;
        OPC_VLD_IN <= 1'b1;
        PAIR_IN    <= v;
        BANK_IN    <= v[2:0];
        pins       <= v[3:0];
        a = {bank_q, pair_q};
        s = {bank_q, pair_q[7:4], op[1:0]};
        m.stb = 1'b0;
        if (op[7:4] == 4'h2 && op[0]) pair_q = v;
        else if (op[7:2] == rio_pkg::OP_WR_ST_HI) sts[s] = m.acc;
        else if (op[7:2] == rio_pkg::OP_RD_ST_HI) m.acc = sts[s];
        else case (op)
            rio_pkg::OP_BANK:     bank_q = v[2:0];
            rio_pkg::OP_WR_MEM:   dat[a] = m.acc;
            rio_pkg::OP_WR_RPORT: m.rp[{bank_q, pair_q[7:6]}*4 +: 4] = m.acc;
            rio_pkg::OP_WR_OPORT: m.op[pair_q[3:0]*4 +: 4] = m.acc;
            rio_pkg::OP_PGM_ACC: begin
                dat[a] = m.acc;
                m.stb  = 1'b1;
                m.half = h;
                h      = ~h;
            end
            rio_pkg::OP_SUB_MEM:  {m.cy, m.acc} = {1'b0, m.acc} + {1'b0, ~dat[a]} + !m.cy;
            rio_pkg::OP_RD_MEM:   m.acc = dat[a];
            rio_pkg::OP_RD_OPORT: m.acc = (v[3:0] & ~OPORT_DIR_IN) | (OPORT_MASK_IN & OPORT_DIR_IN);
            rio_pkg::OP_ADD_MEM:  {m.cy, m.acc} = {1'b0, m.acc} + {1'b0, dat[a]} + m.cy;
            default: ;
        endcase
        q.push_back(m);
    endtask
    // Marks each cycle whose instruction was taken, so its result is due half a cycle later.
    always @(posedge CLK_IN) pend <= OPC_VLD_IN && !RST_IN;
    // Takes the oldest note and compares it with what the design shows.
    always @(negedge CLK_IN) begin
        if (pend) begin
            if (q.size() == 0) miscompares++;
            else begin
                e = q.pop_front();
                chk_alu({ACC_OUT, CY_OUT}, {e.acc, e.cy});
                chk_port({3'h0, OPORT_OUT, RPORT_OUT, PGM_STB_OUT},
                         {3'h0, e.op, e.rp, e.stb});
                if (e.stb) chk_alu({PGM_DATA_OUT, PGM_HALF_OUT}, {e.acc, e.half});
            end
        end
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Every group code in one back-to-back run, with refused codes 0x00 and 0x20 at the end.
    initial begin
        OPC_VLD_IN = 1'b0;
        OPC_IN = 8'h00;
        PAIR_IN = 8'h00;
        BANK_IN = 3'h0;
        pins = 4'h0;
        RST_IN = 1'b1;
        m = '0;
        h = 1'b0;
        pair_q = 8'h00;
        bank_q = 3'h0;
        pend = 1'b0;
        miscompares = 0;
        tests_run = 0;
        void'($urandom(90));
        repeat (4) @(posedge CLK_IN);
        RST_IN <= 1'b0;
        repeat (40) begin
            // All four status characters are written first, since memory has no reset.
            seq = '{8'hfd, {4'h2, 3'($urandom), 1'b1}, 8'hea, 8'he0, 8'he4, 8'he5, 8'he6,
                    8'he7, 8'he4 | 8'($urandom % 4), 8'hea, 8'he9, 8'hec, 8'hed, 8'hee,
                    8'hef, 8'heb, 8'he8, 8'he1, 8'he2, 8'he3};
            foreach (seq[i]) exec(seq[i], 8'($urandom));
            exec(8'he3, 8'($urandom));
            exec(8'h00, 8'($urandom));
            exec(8'h20, 8'($urandom));
        end
        @(posedge CLK_IN);
        OPC_VLD_IN <= 1'b0;
        for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge CLK_IN);
        if (q.size() > 0) miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
